/* core/mcaf_addr_chk.sv */
// Address decode and misalignment check for one bus access
`timescale 1ns/1ps
module mcaf_addr_chk import mcaf_pkg::*; (
  // Access under test
  input  wire logic [31:0] addr,
  input  wire logic [1:0]  accSize,
  input  wire logic [1:0]  accType,
  input  wire logic        accMaster,
  input  wire logic        remapped,
  // Decode results
  output logic             undefAddr,
  output logic             misalAddr,
  output logic             flashSel
);

  // Word needs bits 1:0 clear, half-word needs bit 0 clear
  function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] low);
    misaligned = ((sz == SZ_WORD) && (low != 2'h0)) || ((sz == SZ_HALF) && low[0]);
  endfunction : misaligned

  logic [3:0] area;
  logic [7:0] slot;

  // Area and slot decode; slot 3 is deliberately tolerated without abort
  always_comb begin
    area      = addr[AREA_MSB:AREA_LSB];
    slot      = addr[SUB_MSB:SUB_LSB];
    undefAddr = 1'b0;
    flashSel  = 1'b0;
    if (area == AREA_INTERNAL) begin
      flashSel  = (slot == SUB_FLASH) || ((slot == SUB_AREA0) && !remapped);
      undefAddr = (slot != SUB_AREA0) && (slot != SUB_FLASH) && (slot != SUB_SRAM) && (slot != SUB_NO_ABORT);
    end else if (area != AREA_PERIPH) begin
      undefAddr = 1'b1;
    end
  end

  // Processor instruction fetches escape the check
  assign misalAddr = !((accType == ACC_FETCH) && (accMaster == MST_CPU)) &&
                     misaligned(accSize, addr[1:0]);

endmodule : mcaf_addr_chk

/* core/mcaf_page_buf.sv */
// Write-only flash page latch, drained by the programming engine
`timescale 1ns/1ps
module mcaf_page_buf import mcaf_pkg::*; (
  // Clock
  input  wire logic                    core_clk,
  // Bus side write
  input  wire logic                    wrEn,
  input  wire logic [PAGE_WORDS_W-1:0] wrIdx,
  input  wire logic [31:0]             wrData,
  // Programming side read
  input  wire logic [PAGE_WORDS_W-1:0] rdIdx,
  output logic      [31:0]             rdData
);

  logic [31:0] mem [PAGE_WORDS];

  // Storage holds no reset; contents are undefined until a page is written
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  // Registered read port
  always_ff @(posedge core_clk) begin
    rdData <= mem[rdIdx];
  end

endmodule : mcaf_page_buf

/* core/mcaf_pkg.sv */
// Shared constants for the memory controller abort, remap and flash read block
package mcaf_pkg;

  // Register offsets on the register port
  localparam logic [7:0] REG_REMAP        = 8'h00;
  localparam logic [7:0] REG_ABORT_STATUS = 8'h04;
  localparam logic [7:0] REG_ABORT_ADDR   = 8'h08;

  // Remap control field
  localparam int BIT_REMAP_TOGGLE = 0;

  // Abort status field positions
  localparam int ASR_UNDEF    = 0;
  localparam int ASR_MISAL    = 1;
  localparam int ASR_SIZE_LO  = 8;
  localparam int ASR_TYPE_LO  = 10;
  localparam int ASR_DMA_SRC  = 16;
  localparam int ASR_CPU_SRC  = 17;
  localparam int ASR_DMA_SEEN = 24;
  localparam int ASR_CPU_SEEN = 25;

  // Reset values
  localparam logic [31:0] ABORT_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ABORT_ADDR_RST   = 32'h0000_0000;

  // Access size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Access type codes
  localparam logic [1:0] ACC_READ  = 2'h0;
  localparam logic [1:0] ACC_WRITE = 2'h1;
  localparam logic [1:0] ACC_FETCH = 2'h2;

  // Bus master identity
  localparam logic MST_DMA = 1'b0;
  localparam logic MST_CPU = 1'b1;

  // Top-level area decode on address bits 31:28
  localparam int         AREA_MSB      = 31;
  localparam int         AREA_LSB      = 28;
  localparam logic [3:0] AREA_INTERNAL = 4'h0;
  localparam logic [3:0] AREA_PERIPH   = 4'hf;

  // Internal memory 1 MByte slots on address bits 27:20
  localparam int         SUB_MSB      = 27;
  localparam int         SUB_LSB      = 20;
  localparam logic [7:0] SUB_AREA0    = 8'h00;
  localparam logic [7:0] SUB_FLASH    = 8'h01;
  localparam logic [7:0] SUB_SRAM     = 8'h02;
  localparam logic [7:0] SUB_NO_ABORT = 8'h03;

  // Flash geometry: 256 KByte array, 256-byte pages, 32 lock regions
  localparam int FLASH_MSB    = 17;
  localparam int WORD_LSB     = 2;
  localparam int FLASH_WORD_W = FLASH_MSB - WORD_LSB + 1;
  localparam int PAGE_MSB     = 7;
  localparam int PAGE_WORDS_W = PAGE_MSB - WORD_LSB + 1;
  localparam int PAGE_WORDS   = 1 << PAGE_WORDS_W;
  localparam int LOCK_BITS    = 32;
  localparam int LOCK_IDX_W   = 5;
  localparam int LOCK_LSB     = FLASH_MSB + 1 - LOCK_IDX_W;
  localparam int GPNV_BITS    = 2;
  localparam int HALF_SEL     = 1;

  // Wait-state field width
  localparam int FWS_W = 2;

  // Flash read sequencer states, Gray along idle -> demand -> prefetch wait
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_DEMAND = 2'b01,
    ST_PFWAIT = 2'b11
  } mcaf_state_t;

endpackage : mcaf_pkg

/* core/mcaf_top.sv */
// Memory controller: remap, abort status and flash read path with read-ahead
// How it works
// - Writing 1 to remap bit 0 toggles area zero remap; writing 0 does nothing.
// - Status bit 0 shows last abort came from an undefined address; resets to zero.
// - Status bit 1 shows last abort came from a misaligned address.
// - Status bits 9:8 hold aborted access size: byte, half-word, word.
// - Status bits 11:10 hold aborted access type: read, write, fetch.
// - Status bit 16 shows last abort was issued by the DMA master.
// - Status bit 17 shows last abort was issued by the processor.
// - Status bit 24 sticks once any DMA abort occurs.
// - Status bit 25 sticks once any processor abort occurs.
// - Abort address register holds the full 32-bit aborted address; resets to zero.
// - Two 32-bit buffers; second half-word fetch starts reading the next word.
// - Read-ahead buffers serve instruction fetches only, never data reads.
// - Wait states programmable 0 to 3; zero gives a two-cycle flash read.
// - One wait state: sequential fetches also alternate long and single-cycle.
// - Two or three wait states: sequential fetches alternate long and single-cycle.
// - Flash reads of 8, 16 and 32 bits are all accepted.
// - Flash decode ignores upper address bits, so contents repeat.
// - Write-only page buffer of one page, reachable across the whole 1 MByte slot.
// - Each lock region has a lock bit, shown on regionLocked for the last page write; locked writes still reach the page latch.
// - Two general-purpose non-volatile bits and 32 lock bits.
// - Only the first flash controller carries security and general-purpose bits.
// - Reading abort status clears the sticky per-master abort flags.
// - Misaligned word or half-word accesses abort; processor fetches unchecked.
`timescale 1ns/1ps
module mcaf_top import mcaf_pkg::*; #(
  parameter bit FIRST_CTRL = 1'b1
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Register port
  input  wire logic [7:0]              regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [31:0]             regRdata,
  // System bus access from the arbitrated master
  input  wire logic                    busReq,
  input  wire logic [31:0]             busAddr,
  input  wire logic [31:0]             busWdata,
  input  wire logic [1:0]              busSize,
  input  wire logic [1:0]              busType,
  input  wire logic                    busMaster,
  output logic                         busReady,
  output logic                         busAbort,
  output logic      [31:0]             busRdata,
  // Flash array read port
  output logic                         flashRd,
  output logic      [FLASH_WORD_W-1:0] flashAddr,
  input  wire logic [31:0]             flashRdata,
  input  wire logic [FWS_W-1:0]        flashWaitStates,
  // Page buffer drain
  input  wire logic [PAGE_WORDS_W-1:0] pageRdIdx,
  output logic      [31:0]             pageRdata,
  // Non-volatile bits
  input  wire logic [LOCK_BITS-1:0]    lockBits,
  input  wire logic [GPNV_BITS-1:0]    gpnvBitsIn,
  input  wire logic                    securityIn,
  output logic                         regionLocked,
  output logic      [GPNV_BITS-1:0]    gpnvBits,
  output logic                         securityBit,
  output logic                         remapActive
);

  // Tag compare shared by both read buffers
  function automatic logic tagHit(input logic valid, input logic [FLASH_WORD_W-1:0] tag,
                                  input logic [FLASH_WORD_W-1:0] word);
    tagHit = valid && (tag == word);
  endfunction : tagHit

  mcaf_state_t state_r, state_nxt;

  logic                    remap_r;
  logic                    undefHit, misalHit, flashSel;
  logic                    accept, abortNow, isFetch, isWrite, pageWr;
  logic [FLASH_WORD_W-1:0] reqWord, curWord;
  logic                    undef_r, misal_r, dmaSrc_r, cpuSrc_r, dmaSeen_r, cpuSeen_r;
  logic [1:0]              abtSize_r, abtType_r;
  logic [31:0]             abtAddr_r, statusWord;
  logic                    rdStatus;
  logic [FLASH_WORD_W-1:0] reqTag_r;
  logic                    reqHi_r, reqFetch_r;
  logic                    portBusy_r, portPf_r, portDone;
  logic [FWS_W-1:0]        cnt_r;
  logic [FLASH_WORD_W-1:0] bufTag_r, pfTag_r;
  logic [31:0]             bufData_r, pfData_r;
  logic                    bufValid_r, pfValid_r;
  logic                    respNow, startDemand, startPf, fillBuf, moveToBuf;
  logic [31:0]             respData;
  logic [FLASH_WORD_W-1:0] pfWord;
  logic [LOCK_IDX_W-1:0]   lockIdx;

  mcaf_addr_chk u_addr_chk (
    .addr      (busAddr),
    .accSize   (busSize),
    .accType   (busType),
    .accMaster (busMaster),
    .remapped  (remap_r),
    .undefAddr (undefHit),
    .misalAddr (misalHit),
    .flashSel  (flashSel)
  );

  // Request qualification; only one access is outstanding at a time
  assign accept   = busReq && (state_r == ST_IDLE);
  assign abortNow = accept && (undefHit || misalHit);
  assign isFetch  = (busType == ACC_FETCH);
  assign isWrite  = (busType == ACC_WRITE);
  assign reqWord  = busAddr[FLASH_MSB:WORD_LSB];
  assign pageWr   = accept && !abortNow && flashSel && isWrite;
  assign portDone = portBusy_r && (cnt_r == '0);
  assign rdStatus = regRd && (regAddr == REG_ABORT_STATUS);
  assign lockIdx  = busAddr[FLASH_MSB:LOCK_LSB];

  // Remap toggles only on a written 1; nothing else touches it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      remap_r <= 1'b0;
    end else if (regWr && (regAddr == REG_REMAP) && regWdata[BIT_REMAP_TOGGLE]) begin
      remap_r <= ~remap_r;
    end
  end

  // Last-abort capture: cause, size, type, source and address
  always_ff @(posedge core_clk) begin
    if (reset) begin
      undef_r   <= ABORT_STATUS_RST[ASR_UNDEF];
      misal_r   <= ABORT_STATUS_RST[ASR_MISAL];
      abtSize_r <= ABORT_STATUS_RST[ASR_SIZE_LO +: 2];
      abtType_r <= ABORT_STATUS_RST[ASR_TYPE_LO +: 2];
      dmaSrc_r  <= ABORT_STATUS_RST[ASR_DMA_SRC];
      cpuSrc_r  <= ABORT_STATUS_RST[ASR_CPU_SRC];
      abtAddr_r <= ABORT_ADDR_RST;
    end else if (abortNow) begin
      undef_r   <= undefHit;
      misal_r   <= misalHit && !undefHit;
      abtSize_r <= busSize;
      abtType_r <= busType;
      dmaSrc_r  <= (busMaster == MST_DMA);
      cpuSrc_r  <= (busMaster == MST_CPU);
      abtAddr_r <= busAddr;
    end
  end

  // Sticky flags: a new abort in the reading cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dmaSeen_r <= ABORT_STATUS_RST[ASR_DMA_SEEN];
      cpuSeen_r <= ABORT_STATUS_RST[ASR_CPU_SEEN];
    end else begin
      if (abortNow && (busMaster == MST_DMA)) begin
        dmaSeen_r <= 1'b1;
      end else if (rdStatus) begin
        dmaSeen_r <= 1'b0;
      end
      if (abortNow && (busMaster == MST_CPU)) begin
        cpuSeen_r <= 1'b1;
      end else if (rdStatus) begin
        cpuSeen_r <= 1'b0;
      end
    end
  end

  // Status word assembly, unassigned bits held at zero
  always_comb begin
    statusWord                   = '0;
    statusWord[ASR_UNDEF]        = undef_r;
    statusWord[ASR_MISAL]        = misal_r;
    statusWord[ASR_SIZE_LO +: 2] = abtSize_r;
    statusWord[ASR_TYPE_LO +: 2] = abtType_r;
    statusWord[ASR_DMA_SRC]      = dmaSrc_r;
    statusWord[ASR_CPU_SRC]      = cpuSrc_r;
    statusWord[ASR_DMA_SEEN]     = dmaSeen_r;
    statusWord[ASR_CPU_SEEN]     = cpuSeen_r;
  end

  // Read data one cycle after the strobe; remap is write-only and reads zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        REG_ABORT_STATUS: regRdata <= statusWord;
        REG_ABORT_ADDR:   regRdata <= abtAddr_r;
        default:          regRdata <= '0;
      endcase
    end
  end

  // Request details kept for multi-cycle flash reads
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reqTag_r   <= '0;
      reqHi_r    <= 1'b0;
      reqFetch_r <= 1'b0;
    end else if (accept) begin
      reqTag_r   <= reqWord;
      reqHi_r    <= busAddr[HALF_SEL];
      reqFetch_r <= isFetch;
    end
  end

  // Read sequencing: buffer hits answer at once, misses go to the array
  always_comb begin
    state_nxt   = state_r;
    respNow     = 1'b0;
    respData    = '0;
    startDemand = 1'b0;
    startPf     = 1'b0;
    fillBuf     = 1'b0;
    moveToBuf   = 1'b0;
    curWord     = accept ? reqWord : reqTag_r;
    pfWord      = curWord + 1'b1;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          if (abortNow || !flashSel || isWrite) begin
            respNow = 1'b1;
          end else if (isFetch && tagHit(bufValid_r, bufTag_r, reqWord)) begin
            respNow  = 1'b1;
            respData = bufData_r;
            startPf  = busAddr[HALF_SEL] && !tagHit(pfValid_r, pfTag_r, pfWord);
          end else if (isFetch && tagHit(pfValid_r, pfTag_r, reqWord)) begin
            respNow   = 1'b1;
            respData  = pfData_r;
            moveToBuf = 1'b1;
            startPf   = busAddr[HALF_SEL];
          end else if (isFetch && portBusy_r && portPf_r && (flashAddr == reqWord)) begin
            state_nxt = ST_PFWAIT;
          end else begin
            startDemand = 1'b1;
            state_nxt   = ST_DEMAND;
          end
        end
      end
      ST_DEMAND: begin
        if (portDone) begin
          respNow   = 1'b1;
          respData  = flashRdata;
          fillBuf   = reqFetch_r;
          startPf   = reqFetch_r && reqHi_r;
          state_nxt = ST_IDLE;
        end
      end
      ST_PFWAIT: begin
        if (tagHit(pfValid_r, pfTag_r, reqTag_r)) begin
          respNow   = 1'b1;
          respData  = pfData_r;
          moveToBuf = 1'b1;
          startPf   = reqHi_r;
          state_nxt = ST_IDLE;
        end else if (!portBusy_r) begin
          startDemand = 1'b1;
          state_nxt   = ST_DEMAND;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Array port: a demand read pre-empts any read-ahead in flight
  always_ff @(posedge core_clk) begin
    if (reset) begin
      portBusy_r <= 1'b0;
      portPf_r   <= 1'b0;
      cnt_r      <= '0;
      flashAddr  <= '0;
    end else if (startDemand) begin
      portBusy_r <= 1'b1;
      portPf_r   <= 1'b0;
      cnt_r      <= flashWaitStates;
      flashAddr  <= curWord;
    end else if (startPf) begin
      portBusy_r <= 1'b1;
      portPf_r   <= 1'b1;
      cnt_r      <= flashWaitStates;
      flashAddr  <= pfWord;
    end else if (portDone) begin
      portBusy_r <= 1'b0;
    end else if (portBusy_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Array read strobe follows the port, straight from its flop
  assign flashRd = portBusy_r;

  // Read-ahead buffer fills when its own array read completes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pfValid_r <= 1'b0;
      pfTag_r   <= '0;
      pfData_r  <= '0;
    end else if (portDone && portPf_r) begin
      pfValid_r <= 1'b1;
      pfTag_r   <= flashAddr;
      pfData_r  <= flashRdata;
    end
  end

  // Current fetch buffer, loaded from the array or from the read-ahead buffer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bufValid_r <= 1'b0;
      bufTag_r   <= '0;
      bufData_r  <= '0;
    end else if (fillBuf) begin
      bufValid_r <= 1'b1;
      bufTag_r   <= reqTag_r;
      bufData_r  <= flashRdata;
    end else if (moveToBuf) begin
      bufValid_r <= 1'b1;
      bufTag_r   <= pfTag_r;
      bufData_r  <= pfData_r;
    end
  end

  // Bus answer, registered; aborted accesses are cancelled and return zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busReady <= 1'b0;
      busAbort <= 1'b0;
      busRdata <= '0;
    end else begin
      busReady <= respNow;
      busAbort <= respNow && abortNow;
      busRdata <= respData;
    end
  end

  // Page latch takes word writes anywhere in the flash slot
  mcaf_page_buf u_page_buf (
    .core_clk (core_clk),
    .wrEn     (pageWr),
    .wrIdx    (busAddr[PAGE_MSB:WORD_LSB]),
    .wrData   (busWdata),
    .rdIdx    (pageRdIdx),
    .rdData   (pageRdata)
  );

  // Lock state of the region last written, for the programming engine
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regionLocked <= 1'b0;
    end else if (pageWr) begin
      regionLocked <= lockBits[lockIdx];
    end
  end

  // Non-volatile bits exported only by the first controller
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gpnvBits    <= '0;
      securityBit <= 1'b0;
    end else begin
      gpnvBits    <= FIRST_CTRL ? gpnvBitsIn : '0;
      securityBit <= FIRST_CTRL && securityIn;
    end
  end

  // Remap state published to the memory decode
  assign remapActive = remap_r;

endmodule : mcaf_top

/* verif/mcaf_flash_model.sv */
// Flash array model answering the controller's read port
`timescale 1ns/1ps
module mcaf_flash_model import mcaf_pkg::*; (
  // Clock
  input  wire logic                    core_clk,
  // Array read port
  input  wire logic                    flashRd,
  input  wire logic [FLASH_WORD_W-1:0] flashAddr,
  output logic      [31:0]             flashRdata
);
  logic [31:0] junk_r = 32'h5a5a_a5a5;
  // Idle bus flips every cycle so stale data can never pass as valid
  always_ff @(posedge core_clk) junk_r <= ~junk_r;
  // Each word carries its address and its inverse, so aliasing shows up
  assign flashRdata = flashRd ? {~flashAddr, flashAddr} : junk_r;
endmodule : mcaf_flash_model

/* verif/mcaf_top_chk.sv */
// Assertion checker for the memory controller register port and bus answers
`timescale 1ns/1ps
module mcaf_top_chk import mcaf_pkg::*; (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // Register port
  input wire logic [7:0]        regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  // System bus
  input wire logic              busReq,
  input wire logic [31:0]       busAddr,
  input wire logic [1:0]        busSize,
  input wire logic [1:0]        busType,
  input wire logic              busMaster,
  input wire logic              busReady,
  input wire logic              busAbort,
  input wire logic [FWS_W-1:0]  flashWaitStates,
  input wire logic              remapActive
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic       busy_r, ok_r, dataFlash_r, mis, legal, taken;
  logic [3:0] cyc_r;
  logic [1:0] ws_r;
  // Processor fetches are never checked for alignment
  assign mis = !(busMaster && busType == ACC_FETCH) &&
               ((busSize == SZ_WORD && busAddr[1:0] != 2'h0) || (busSize == SZ_HALF && busAddr[0]));
  assign legal = ((busAddr[31:28] == AREA_INTERNAL && busAddr[27:20] <= SUB_NO_ABORT) ||
                  busAddr[31:28] == AREA_PERIPH) && !mis;
  assign taken = busReq && (!busy_r || busReady);
  // Outstanding access: legality and age
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else if (taken) begin
      busy_r      <= 1'b1;
      ok_r        <= legal;
      dataFlash_r <= busType == ACC_READ && legal && busAddr[31:28] == AREA_INTERNAL &&
                     (busAddr[27:20] == SUB_FLASH || (busAddr[27:20] == SUB_AREA0 && !remapActive));
      ws_r        <= flashWaitStates;
      cyc_r       <= 4'h1;
    end else begin
      if (busReady) busy_r <= 1'b0;
      cyc_r <= cyc_r + 4'h1;
    end
  end
  a_remap_toggle: assert property (regWr && regAddr == REG_REMAP && regWdata[0] |=>
    remapActive != $past(remapActive)) else $error("remap did not toggle");
  a_remap_hold: assert property (!(regWr && regAddr == REG_REMAP && regWdata[0]) |=>
    $stable(remapActive)) else $error("stray remap change");
  a_status_unused: assert property (regRd && regAddr == REG_ABORT_STATUS |=>
    (regRdata & 32'hfcfc_f0fc) == 32'h0) else $error("unused bits set");
  a_unmapped_zero: assert property (regRd && (regAddr == REG_REMAP || regAddr > REG_ABORT_ADDR) |=>
    regRdata == 32'h0) else $error("unmapped read not zero");
  a_master_onehot: assert property (regRd && regAddr == REG_ABORT_STATUS |=>
    (regRdata[ASR_DMA_SRC] ^ regRdata[ASR_CPU_SRC]) == (regRdata[ASR_UNDEF] | regRdata[ASR_MISAL]))
    else $error("bad abort source");
  a_abort_legal: assert property (busReady && busy_r && ok_r |-> !busAbort)
    else $error("legal access aborted");
  a_abort_fast: assert property (busReady && busy_r && !ok_r |-> busAbort && cyc_r == 4'h1)
    else $error("late abort");
  a_read_timing: assert property (busReady && busy_r && dataFlash_r |-> cyc_r == {2'h0, ws_r} + 4'h2)
    else $error("flash read latency");
  a_ready_bound: assert property (taken |-> ##[1:12] busReady)
    else $error("no bus answer");
  a_abort_pulse: assert property (busAbort |-> busReady)
    else $error("abort without ready");
endmodule : mcaf_top_chk

bind mcaf_top mcaf_top_chk u_chk (.*);

/* verif/mcaf_top_tb.sv */
// Self-checking bench for the memory controller block
`timescale 1ns/1ps
module mcaf_top_tb import mcaf_pkg::*; ;
  logic                    core_clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, busReq = 1'b0;
  logic                    busMaster = 1'b0, busReady, busAbort, flashRd, regionLocked, securityBit, remapActive, ab;
  logic [7:0]              regAddr = 8'h00;
  logic [31:0]             regWdata = 32'h0, busAddr = 32'h0, busWdata = 32'h0, regRdata, busRdata, flashRdata;
  logic [31:0]             pageRdata, lat, dat, rv;
  logic [1:0]              busSize = 2'h0, busType = 2'h0, gpnvBits;
  logic [FWS_W-1:0]        flashWaitStates = 2'h0;
  logic [PAGE_WORDS_W-1:0] pageRdIdx = 6'h02;
  logic [FLASH_WORD_W-1:0] flashAddr;
  int                      fails = 0, total_checks = 0;
  // Abort cases and the status each leaves
  localparam logic [31:0] AA [4] = '{32'h3000_0010, 32'h0020_0003, 32'h5000_0000, 32'h0040_0000};
  localparam logic [1:0]  AS [4] = '{SZ_WORD, SZ_HALF, SZ_WORD, SZ_BYTE};
  localparam logic [1:0]  AT [4] = '{ACC_WRITE, ACC_READ, ACC_FETCH, ACC_READ};
  localparam logic        AM [4] = '{MST_DMA, MST_CPU, MST_CPU, MST_DMA};
  localparam logic [31:0] ES [4] = '{32'h0101_0601, 32'h0202_0102, 32'h0202_0a01, 32'h0101_0001};

  mcaf_top uut (.core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .busReq(busReq), .busAddr(busAddr), .busWdata(busWdata),
    .busSize(busSize), .busType(busType), .busMaster(busMaster), .busReady(busReady), .busAbort(busAbort),
    .busRdata(busRdata), .flashRd(flashRd), .flashAddr(flashAddr), .flashRdata(flashRdata),
    .flashWaitStates(flashWaitStates), .pageRdIdx(pageRdIdx), .pageRdata(pageRdata),
    .lockBits(32'h0000_0004), .gpnvBitsIn(2'h2), .securityIn(1'b1), .regionLocked(regionLocked),
    .gpnvBits(gpnvBits), .securityBit(securityBit), .remapActive(remapActive));
  mcaf_flash_model u_flash (.core_clk(core_clk), .flashRd(flashRd), .flashAddr(flashAddr), .flashRdata(flashRdata));

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // One-cycle register strobes, read data taken in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    rv = regRdata;
  endtask : rd

  // One bus request; lat is edges from taking to ready
  task automatic bus(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] ty, input logic m);
    @(posedge core_clk);
    busReq <= 1'b1;
    busAddr <= a;
    busSize <= sz;
    busType <= ty;
    busMaster <= m;
    busWdata <= ~a;
    @(posedge core_clk);
    busReq <= 1'b0;
    lat = 1;
    #1;
    while (busReady !== 1'b1 && lat < 20) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    if (lat == 20) begin
      fails++;
      final_report();
    end
    dat = busRdata;
    ab = busAbort;
  endtask : bus

  task automatic t_remap;
    logic [31:0] w [4] = '{32'hffff_fffe, 32'h1, 32'h1, 32'h1};
    logic        e [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    foreach (w[i]) begin
      wr(REG_REMAP, w[i]);
      chk("remap", {31'h0, e[i]}, {31'h0, remapActive});
    end
    wr(REG_REMAP, 32'h1);
    wr(REG_ABORT_STATUS, 32'hffff_ffff);
    wr(REG_ABORT_ADDR, 32'hffff_ffff);
    rd(REG_ABORT_STATUS);
    chk("status", ABORT_STATUS_RST, rv);
    rd(REG_ABORT_ADDR);
    chk("abort address", ABORT_ADDR_RST, rv);
    rd(REG_REMAP);
    chk("remap read", 32'h0, rv);
    chk("nv bits", 32'h6, {29'h0, securityBit, gpnvBits});
  endtask : t_remap

  task automatic t_abort;
    for (int i = 0; i < 4; i++) begin
      bus(AA[i], AS[i], AT[i], AM[i]);
      chk("abort", 32'h1, {31'h0, ab});
      rd(REG_ABORT_STATUS);
      chk("abort status", ES[i], rv);
      rd(REG_ABORT_ADDR);
      chk("abort address", AA[i], rv);
    end
    rd(REG_ABORT_STATUS);
    chk("sticky cleared", 32'h0001_0001, rv);
    bus(32'h0010_0002, SZ_WORD, ACC_FETCH, MST_CPU);
    chk("fetch unchecked", 32'h0, {31'h0, ab});
  endtask : t_abort

  task automatic t_flash;
    logic [31:0] a;
    for (int ws = 0; ws < 4; ws++) begin
      @(posedge core_clk);
      flashWaitStates <= ws[1:0];
      a = 32'h0010_0100 + 32'(ws * 16);
      bus(a, SZ_WORD, ACC_READ, MST_CPU);
      chk("read latency", 32'(ws + 2), lat);
      chk("read data", {~a[17:2], a[17:2]}, dat);
      bus(a + 32'h1, SZ_BYTE, ACC_READ, MST_DMA);
      chk("byte read latency", 32'(ws + 2), lat);
      bus(a + 32'h0004_0000, SZ_WORD, ACC_READ, MST_CPU);
      chk("alias data", {~a[17:2], a[17:2]}, dat);
      bus(a + 32'h80, SZ_HALF, ACC_FETCH, MST_CPU);
      chk("fetch miss", 32'(ws + 2), lat);
      bus(a + 32'h82, SZ_HALF, ACC_FETCH, MST_CPU);
      chk("fetch hit", 32'h1, lat);
    end
  endtask : t_flash

  task automatic t_page;
    bus(32'h0010_0008, SZ_WORD, ACC_WRITE, MST_CPU);
    chk("unlocked region", 32'h0, {31'h0, regionLocked});
    bus(32'h0010_4008, SZ_WORD, ACC_WRITE, MST_CPU);
    chk("locked region", 32'h1, {31'h0, regionLocked});
    bus(32'h0010_400a, SZ_WORD, ACC_WRITE, MST_CPU);
    repeat (2) @(posedge core_clk);
    #1;
    chk("page word", ~32'h0010_4008, pageRdata);
  endtask : t_page

  // Reset for ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_remap();
    t_abort();
    t_flash();
    t_page();
    final_report();
  end
endmodule : mcaf_top_tb
